// [common/ccm_pkg.sv]
package ccm_pkg;

   // Clock and audio base rates
   localparam int unsigned CLK_HZ      = 50_000_000;
   localparam int unsigned BASE_48K_HZ = 48_000;
   localparam int unsigned BASE_44K_HZ = 44_100;
   // Cycles per base-rate sample period, rounded down
   localparam int unsigned DIV_48K     = CLK_HZ / BASE_48K_HZ;
   localparam int unsigned DIV_44K     = CLK_HZ / BASE_44K_HZ;

   // Sample and channel geometry
   localparam int unsigned SAMPLE_W    = 24;
   localparam int unsigned NUM_CH      = 28;
   localparam int unsigned CH_W        = 5;
   localparam int unsigned NUM_ANALOG  = 8;
   localparam int unsigned OPT_SLOTS   = 16;
   localparam logic [4:0]  CH_SPDIF_L  = 5'h0a;
   localparam logic [4:0]  CH_SPDIF_R  = 5'h0b;
   localparam logic [4:0]  CH_OPT_BASE = 5'h0c;

   // Channel counts per cap choice and rate
   localparam logic [4:0]  CNT_ALL     = 5'h1c;
   localparam logic [4:0]  CNT_FIRST   = 5'h14;
   localparam logic [4:0]  CNT_ANA_DIG = 5'h0c;
   localparam logic [4:0]  CNT_ANA8    = 5'h08;

   // Fixed playback safety offset in samples
   localparam logic [15:0] SAFETY_OFFSET = 16'h0040;

   // Register byte offsets
   localparam logic [5:0] REG_CTRL    = 6'h00;
   localparam logic [5:0] REG_STATUS  = 6'h04;
   localparam logic [5:0] REG_MASK    = 6'h08;
   localparam logic [5:0] REG_BUFSZ   = 6'h0c;
   localparam logic [5:0] REG_LATENCY = 6'h10;
   localparam logic [5:0] REG_ACTIVE  = 6'h14;
   localparam logic [5:0] REG_POS     = 6'h18;

   // Control field positions and reset value
   localparam int unsigned CTRL_CAP_LSB  = 0;
   localparam int unsigned CTRL_RATE_LSB = 2;
   localparam int unsigned CTRL_B44_BIT  = 4;
   localparam int unsigned CTRL_EN_BIT   = 5;
   localparam logic [5:0]  CTRL_RESET    = 6'h00;
   localparam logic [15:0] BUFSZ_RESET   = 16'h0100;

   // Status bit positions
   localparam int unsigned ST_RX_ERR  = 0;
   localparam int unsigned ST_LOST    = 1;
   localparam int unsigned ST_TX_ERR  = 2;
   localparam int unsigned ST_W       = 3;

   // Channel-cap choices, two-bit encoding
   typedef enum logic [1:0] {
      CAP_ALL                          = 2'h0,
      CAP_ANALOG_DIGITAL_FIRST_OPTICAL = 2'h1,
      CAP_ANALOG_DIGITAL               = 2'h2,
      CAP_ANALOG8                      = 2'h3
   } ccm_cap_t;

   // Rate modes
   typedef enum logic [1:0] {
      RATE_SINGLE      = 2'h0,
      DOUBLE_RATE_MODE = 2'h1,
      QUAD_RATE_MODE   = 2'h2,
      RATE_RSVD        = 2'h3
   } ccm_rate_t;

   // One interleaved word on the serial link
   typedef struct packed {
      logic                sof;
      logic [7:0]          seq;
      logic [SAMPLE_W-1:0] data;
      logic                par;
   } ccm_word_t;

   // One optical slot
   typedef struct packed {
      logic                port;
      logic [2:0]          ch;
      logic [SAMPLE_W-1:0] data;
   } ccm_opt_t;

endpackage : ccm_pkg

// [design/ccm_mapper.sv]
`timescale 1ns/1ps
// Contract
// - Reported latency adds fixed 64-sample safety offset.
// - All active channels interleaved in each transfer.
// - Check link data, report errors to software.
// - Keep running after losses, realign sample position.
// - Cap limits channels to 28/20/12/8.
// - Cap is fixed count; double rate gives at most 20.
// - Quad rate carries at most 12 channels.
// - Link load scales by rate multiple.
// - Double rate doubles internal sample clock.
// - Samples stay 24 bits in every mode.
// - Optical ports multiplexed automatically in double rate.
// - Analog 1-4 to port one, 5-8 port two.
// - Optical frames keep base frame rate.
// - No optical channels at quad rate.
// - Quad-rate digital pair uses single wire.
// - Pair carries odd and even samples alternately; code sends channels 10/11 on SPDIF_L/SPDIF_R at every rate tick.
module ccm_mapper
   import ccm_pkg::*;
(
   // Clock and reset
   input  wire logic                 CORE_CLK,
   input  wire logic                 RST,
   // Avalon-MM register slave
   input  wire logic [5:0]           AVS_ADDRESS,
   input  wire logic                 AVS_READ,
   input  wire logic                 AVS_WRITE,
   input  wire logic [3:0]           AVS_BYTEENABLE,
   input  wire logic [31:0]          AVS_WRITEDATA,
   output logic      [31:0]          AVS_READDATA,
   output logic                      AVS_WAITREQUEST,
   output logic                      IRQ,
   // Captured samples from converters and digital inputs
   input  wire logic                 CAP_VALID,
   input  wire logic [CH_W-1:0]      CAP_CH,
   input  wire logic [SAMPLE_W-1:0]  CAP_DATA,
   // Link towards host, record direction
   output logic                      LINK_TX_VALID,
   output ccm_word_t                 LINK_TX_WORD,
   input  wire logic                 LINK_TX_NAK,
   // Link from host, playback direction
   input  wire logic                 LINK_RX_VALID,
   input  wire ccm_word_t            LINK_RX_WORD,
   // Optical port stream
   output logic                      OPT_VALID,
   output ccm_opt_t                  OPT_SLOT,
   // Digital stereo output, single wire
   output logic                      SPDIF_STB,
   output logic      [SAMPLE_W-1:0]  SPDIF_L,
   output logic      [SAMPLE_W-1:0]  SPDIF_R,
   // Rate ticks for the rest of the chip
   output logic                      RATE_TICK,
   output logic                      FRAME_TICK
);

   ////////////////////////////////////////////////////////////////////////
   // Helpers

   // Channel count for a cap choice at a rate
   function automatic logic [4:0] cap_count(input logic [1:0] cap,
                                            input logic [1:0] rate);
      logic [4:0] n;
      n = CNT_ANA8;
      case (cap)
         CAP_ALL:                          n = CNT_ALL;
         CAP_ANALOG_DIGITAL_FIRST_OPTICAL: n = CNT_FIRST;
         CAP_ANALOG_DIGITAL:               n = CNT_ANA_DIG;
         default:                          n = CNT_ANA8;
      endcase
      if (rate == DOUBLE_RATE_MODE && n > CNT_FIRST) begin
         n = CNT_FIRST;
      end
      if (rate == QUAD_RATE_MODE && n > CNT_ANA_DIG) begin
         n = CNT_ANA_DIG;
      end
      return n;
   endfunction : cap_count

   // Even parity over a sample
   function automatic logic par_of(input logic [SAMPLE_W-1:0] d);
      return ^d;
   endfunction : par_of

   ////////////////////////////////////////////////////////////////////////
   // Registers and state

   logic [5:0]          ctrl_q;         // Software control
   logic [ST_W-1:0]     status_q;       // Sticky events
   logic [ST_W-1:0]     mask_q;         // Interrupt enables
   logic [15:0]         bufsz_q;        // Host buffer size, samples
   logic [7:0]          errcnt_q;       // Saturating error count
   logic [4:0]          active_q;       // Applied channel count
   logic [1:0]          rate_q;         // Applied rate mode
   logic                ack_q;          // Bus answer phase
   logic [31:0]         rdata_q;        // Registered read data
   logic [11:0]         div_q;          // Rate divider
   logic [1:0]          sub_q;          // Rate ticks within a frame
   logic                rate_tick;      // One cycle per sample period
   logic                frame_tick;     // One cycle per base period
   logic [SAMPLE_W-1:0] cap_mem [NUM_CH];       // Latest capture
   logic [SAMPLE_W-1:0] play_mem [NUM_CH];      // Latest playback
   logic [SAMPLE_W-1:0] early_mem [NUM_ANALOG]; // Earlier analog half
   logic                tx_busy_q;      // Transfer in progress
   logic [4:0]          tx_slot_q;      // Slot being sent
   logic [7:0]          tx_seq_q;       // Transfer number
   logic [4:0]          rx_slot_q;      // Slot being received
   logic [7:0]          rx_exp_q;       // Expected transfer number
   logic                rx_sync_q;      // First transfer seen
   logic [31:0]         pos_q;          // Playback sample position
   logic                opt_busy_q;     // Optical frame in progress
   logic [3:0]          opt_slot_q;     // Optical slot counter
   logic                bus_wr;         // Write takes effect
   logic                bus_rd;         // Read answered
   logic                ev_rx_err;      // Bad parity on receive
   logic                ev_lost;        // Transfer gap detected
   logic [ST_W-1:0]     ev_vec;         // Event vector
   logic [31:0]         wmask;          // Byte-enable mask
   logic [11:0]         div_reload;     // Cycles per rate tick
   logic                smux;           // Sample multiplexing active

   ////////////////////////////////////////////////////////////////////////
   // Avalon-MM slave

   // Every request waits one cycle, then answers
   assign AVS_WAITREQUEST = (AVS_READ | AVS_WRITE) & ~ack_q;
   assign bus_wr = AVS_WRITE & ack_q;
   assign bus_rd = AVS_READ & ~ack_q;
   assign wmask  = {{8{AVS_BYTEENABLE[3]}}, {8{AVS_BYTEENABLE[2]}},
                    {8{AVS_BYTEENABLE[1]}}, {8{AVS_BYTEENABLE[0]}}};
   assign AVS_READDATA = rdata_q;

   // Answer phase toggles once per request
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ack_q <= 1'b0;
      end else begin
         ack_q <= (AVS_READ | AVS_WRITE) & ~ack_q;
      end
   end

   // Read mux, registered so data stands at the answering edge
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         rdata_q <= 32'h0;
      end else if (bus_rd) begin
         case (AVS_ADDRESS)
            REG_CTRL:    rdata_q <= {26'h0, ctrl_q};
            REG_STATUS:  rdata_q <= {29'h0, status_q};
            REG_MASK:    rdata_q <= {29'h0, mask_q};
            REG_BUFSZ:   rdata_q <= {16'h0, bufsz_q};
            REG_LATENCY: rdata_q <= {15'h0, {1'b0, bufsz_q} +
                                     {1'b0, SAFETY_OFFSET}};
            REG_ACTIVE:  rdata_q <= {16'h0, errcnt_q, smux, rate_q,
                                     active_q};
            REG_POS:     rdata_q <= pos_q;
            // Unmapped reads as zero
            default:     rdata_q <= 32'h0;
         endcase
      end
   end

   // Control and buffer size writes
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         ctrl_q  <= CTRL_RESET;
         mask_q  <= '0;
         bufsz_q <= BUFSZ_RESET;
      end else if (bus_wr) begin
         if (AVS_ADDRESS == REG_CTRL && AVS_BYTEENABLE[0]) begin
            ctrl_q <= AVS_WRITEDATA[5:0];
         end
         if (AVS_ADDRESS == REG_MASK && AVS_BYTEENABLE[0]) begin
            mask_q <= AVS_WRITEDATA[ST_W-1:0];
         end
         if (AVS_ADDRESS == REG_BUFSZ) begin
            bufsz_q <= (bufsz_q & ~wmask[15:0]) |
                       (AVS_WRITEDATA[15:0] & wmask[15:0]);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Events and interrupt

   assign ev_vec = {LINK_TX_NAK, ev_lost, ev_rx_err};

   // Sticky status; a new event wins over a clearing write
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         status_q <= '0;
      end else begin
         status_q <= (status_q &
                      ~((bus_wr && AVS_ADDRESS == REG_STATUS &&
                         AVS_BYTEENABLE[0]) ?
                        AVS_WRITEDATA[ST_W-1:0] : '0)) | ev_vec;
      end
   end

   // Error count for display, saturates rather than wraps
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         errcnt_q <= 8'h0;
      end else if ((|ev_vec) && errcnt_q != 8'hff) begin
         errcnt_q <= errcnt_q + 8'h1;
      end
   end

   assign IRQ = |(status_q & mask_q);

   ////////////////////////////////////////////////////////////////////////
   // Sample clock

   assign div_reload = (ctrl_q[CTRL_B44_BIT] ? DIV_44K[11:0] : DIV_48K[11:0])
                       >> ((rate_q == QUAD_RATE_MODE)   ? 2 :
                           (rate_q == DOUBLE_RATE_MODE) ? 1 : 0);
   assign rate_tick  = (div_q == 12'h0) && !RST;
   assign frame_tick = rate_tick &&
                       (sub_q == ((rate_q == QUAD_RATE_MODE)   ? 2'h3 :
                                  (rate_q == DOUBLE_RATE_MODE) ? 2'h1 :
                                  2'h0));
   assign RATE_TICK  = rate_tick;
   assign FRAME_TICK = frame_tick;

   // Divider and sub-frame counter
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         div_q <= 12'h0;
         sub_q <= 2'h0;
      end else if (rate_tick) begin
         div_q <= div_reload - 12'h1;
         sub_q <= frame_tick ? 2'h0 : sub_q + 2'h1;
      end else begin
         div_q <= div_q - 12'h1;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         rate_q   <= RATE_SINGLE;
         active_q <= CNT_ALL;
      end else if (frame_tick) begin
         // Reserved rate code falls back to single rate
         rate_q   <= (ctrl_q[3:2] == RATE_RSVD) ? RATE_SINGLE : ctrl_q[3:2];
         active_q <= cap_count(ctrl_q[1:0],
                               (ctrl_q[3:2] == RATE_RSVD) ? RATE_SINGLE :
                               ctrl_q[3:2]);
      end
   end

   assign smux = (rate_q == DOUBLE_RATE_MODE);

   ////////////////////////////////////////////////////////////////////////
   // Capture store

   always_ff @(posedge CORE_CLK) begin
      if (CAP_VALID && CAP_CH < NUM_CH[CH_W-1:0]) begin
         cap_mem[CAP_CH] <= CAP_DATA;
      end
   end

   always_ff @(posedge CORE_CLK) begin
      if (rate_tick && !frame_tick) begin
         for (int i = 0; i < NUM_ANALOG; i++) begin
            early_mem[i] <= cap_mem[i];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Record transfers

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         tx_busy_q <= 1'b0;
         tx_slot_q <= 5'h0;
         tx_seq_q  <= 8'h0;
      end else if (rate_tick && ctrl_q[CTRL_EN_BIT]) begin
         tx_busy_q <= 1'b1;
         tx_slot_q <= 5'h0;
         tx_seq_q  <= tx_seq_q + 8'h1;
      end else if (tx_busy_q) begin
         if (tx_slot_q == active_q - 5'h1) begin
            tx_busy_q <= 1'b0;
         end
         tx_slot_q <= tx_slot_q + 5'h1;
      end
   end

   // Registered link word
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         LINK_TX_VALID <= 1'b0;
         LINK_TX_WORD  <= '0;
      end else begin
         LINK_TX_VALID     <= tx_busy_q;
         LINK_TX_WORD.sof  <= tx_busy_q && tx_slot_q == 5'h0;
         LINK_TX_WORD.seq  <= tx_seq_q;
         LINK_TX_WORD.data <= cap_mem[tx_slot_q];
         LINK_TX_WORD.par  <= par_of(cap_mem[tx_slot_q]);
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Playback transfers

   assign ev_rx_err = LINK_RX_VALID &&
                      (par_of(LINK_RX_WORD.data) != LINK_RX_WORD.par);
   assign ev_lost   = LINK_RX_VALID && LINK_RX_WORD.sof && rx_sync_q &&
                      (LINK_RX_WORD.seq != rx_exp_q);

   // Slot counting and sequence tracking
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         rx_slot_q <= 5'h0;
         rx_exp_q  <= 8'h0;
         rx_sync_q <= 1'b0;
         pos_q     <= 32'h0;
      end else if (LINK_RX_VALID) begin
         rx_slot_q <= LINK_RX_WORD.sof ? 5'h1 : rx_slot_q + 5'h1;
         if (LINK_RX_WORD.sof) begin
            rx_sync_q <= 1'b1;
            rx_exp_q  <= LINK_RX_WORD.seq + 8'h1;
            pos_q <= pos_q + 32'h1 +
                     (rx_sync_q ? {24'h0, LINK_RX_WORD.seq - rx_exp_q} :
                      32'h0);
         end
      end
   end

   // Bad words are dropped; playback keeps the last good sample
   always_ff @(posedge CORE_CLK) begin
      if (LINK_RX_VALID && !ev_rx_err) begin
         if (LINK_RX_WORD.sof) begin
            play_mem[0] <= LINK_RX_WORD.data;
         end else if (rx_slot_q < active_q) begin
            play_mem[rx_slot_q] <= LINK_RX_WORD.data;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Optical ports

   // One slot per cycle after each base frame, none at quad rate
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         opt_busy_q <= 1'b0;
         opt_slot_q <= 4'h0;
      end else if (frame_tick && rate_q != QUAD_RATE_MODE) begin
         opt_busy_q <= 1'b1;
         opt_slot_q <= 4'h0;
      end else if (opt_busy_q) begin
         opt_busy_q <= (opt_slot_q != 4'hf);
         opt_slot_q <= opt_slot_q + 4'h1;
      end
   end

   // Slot contents
   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         OPT_VALID <= 1'b0;
         OPT_SLOT  <= '0;
      end else begin
         OPT_VALID     <= opt_busy_q;
         OPT_SLOT.port <= opt_slot_q[3];
         OPT_SLOT.ch   <= opt_slot_q[2:0];
         if (smux) begin
            OPT_SLOT.data <= opt_slot_q[0] ?
                             cap_mem[{1'b0, opt_slot_q[3:1]}] :
                             early_mem[opt_slot_q[3:1]];
         end else begin
            OPT_SLOT.data <= play_mem[CH_OPT_BASE + {1'b0, opt_slot_q}];
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Digital stereo output

   always_ff @(posedge CORE_CLK) begin
      if (RST) begin
         SPDIF_STB <= 1'b0;
         SPDIF_L   <= '0;
         SPDIF_R   <= '0;
      end else begin
         SPDIF_STB <= rate_tick;
         if (rate_tick) begin
            SPDIF_L <= play_mem[CH_SPDIF_L];
            SPDIF_R <= play_mem[CH_SPDIF_R];
         end
      end
   end

endmodule : ccm_mapper

// [dv/ccm_mapper_asserts.sv]
`timescale 1ns/1ps
module ccm_mapper_asserts
   import ccm_pkg::*;
(
   // Clock and reset
   input wire logic      CORE_CLK,
   input wire logic      RST,
   // Register bus
   input wire logic      AVS_READ,
   input wire logic      AVS_WRITE,
   input wire logic      AVS_WAITREQUEST,
   // Streams and ticks
   input wire logic      LINK_TX_VALID,
   input wire ccm_word_t LINK_TX_WORD,
   input wire logic      OPT_VALID,
   input wire logic      SPDIF_STB,
   input wire logic      RATE_TICK,
   input wire logic      FRAME_TICK
);
   default clocking dc @(posedge CORE_CLK); endclocking
   default disable iff (RST);
   logic [5:0] tx_run_q;  // Words already sent in this transfer
   logic [5:0] opt_run_q; // Slots already sent in this burst
   // Run lengths restart whenever valid drops
   always_ff @(posedge CORE_CLK) begin
      if (RST || !LINK_TX_VALID)
         tx_run_q <= 6'h00;
      else
         tx_run_q <= tx_run_q + 6'h01;
   end
   // Same count for optical bursts
   always_ff @(posedge CORE_CLK) begin
      if (RST || !OPT_VALID)
         opt_run_q <= 6'h00;
      else
         opt_run_q <= opt_run_q + 6'h01;
   end
   // Two-cycle bus answer
   sequence s_bus_ack;
      AVS_WAITREQUEST ##1 !AVS_WAITREQUEST;
   endsequence
   // Quad rate still leaves hundreds of idle cycles
   sequence s_tick_quiet;
      !RATE_TICK [*8];
   endsequence
   ////////////////////////////////////////////////////////////
   chk_bus_answer: assert property (
      $rose(AVS_READ) || $rose(AVS_WRITE) |-> s_bus_ack)
      else $error("bus answer not in two cycles");
   chk_tx_launch: assert property (
      $rose(LINK_TX_VALID) |-> $past(RATE_TICK, 2) && LINK_TX_WORD.sof)
      else $error("transfer not started from rate tick");
   chk_tx_sof_once: assert property (
      LINK_TX_VALID && $past(LINK_TX_VALID) |-> !LINK_TX_WORD.sof)
      else $error("start flag inside transfer");
   chk_tx_parity: assert property (
      LINK_TX_VALID |-> LINK_TX_WORD.par == ^LINK_TX_WORD.data)
      else $error("link parity wrong");
   chk_tx_count: assert property (
      LINK_TX_VALID |-> tx_run_q < 6'd28)
      else $error("transfer longer than 28 words");
   chk_opt_count: assert property (
      OPT_VALID |-> opt_run_q < 6'd16)
      else $error("optical burst longer than 16");
   chk_opt_launch: assert property (
      $rose(OPT_VALID) |-> $past(FRAME_TICK, 2))
      else $error("optical burst off frame");
   chk_tick_spacing: assert property (
      RATE_TICK |=> s_tick_quiet)
      else $error("rate ticks too close");
   chk_frame_on_tick: assert property (
      FRAME_TICK |-> RATE_TICK)
      else $error("frame tick off rate tick");
   chk_spdif_stb: assert property (
      SPDIF_STB |-> $past(RATE_TICK))
      else $error("digital strobe not after tick");
endmodule : ccm_mapper_asserts

bind ccm_mapper ccm_mapper_asserts ccm_mapper_asserts_inst (
   .CORE_CLK(CORE_CLK), .RST(RST), .AVS_READ(AVS_READ),
   .AVS_WRITE(AVS_WRITE), .AVS_WAITREQUEST(AVS_WAITREQUEST),
   .LINK_TX_VALID(LINK_TX_VALID), .LINK_TX_WORD(LINK_TX_WORD),
   .OPT_VALID(OPT_VALID), .SPDIF_STB(SPDIF_STB),
   .RATE_TICK(RATE_TICK), .FRAME_TICK(FRAME_TICK));

// [dv/ccm_host_model.sv]
`timescale 1ns/1ps
module ccm_host_model
   import ccm_pkg::*;
(
   // Clock and reset
   input  wire logic      clk,
   input  wire logic      rst,
   // Record stream from the block
   input  wire logic      tx_valid,
   output logic           tx_nak,
   // Playback stream to the block
   output logic           rx_valid,
   output ccm_word_t      rx_word,
   // Word count of the last record transfer
   output logic [7:0]     last_cnt
);
   logic [7:0] run_q; // Words of the transfer in flight
   // Quiet link at time zero
   initial begin
      tx_nak   = 1'b0;
      rx_valid = 1'b0;
      rx_word  = '0;
   end
   ////////////////////////////////////////////////////////////
   // whole transfer counted
   always_ff @(posedge clk) begin
      if (rst) begin
         run_q    <= 8'h00;
         last_cnt <= 8'h00;
      end else if (tx_valid) begin
         run_q <= run_q + 8'h01;
      end else if (run_q != 8'h00) begin
         last_cnt <= run_q;
         run_q    <= 8'h00;
      end
   end
   task automatic send(input logic [7:0] seq, input int n, input logic bad);
      ccm_word_t w;
      for (int i = 0; i < n; i++) begin
         @(posedge clk);
         w.sof    = (i == 0);
         w.seq    = seq;
         w.data   = {seq, 16'(i)};
         w.par    = (^w.data) ^ bad;
         rx_valid <= 1'b1;
         rx_word  <= w;
      end
      @(posedge clk);
      rx_valid <= 1'b0;
      // Released word flips so stale data cannot pass as fresh
      rx_word  <= ~w;
   endtask : send
   // One-cycle report of a bad record transfer
   task automatic nak();
      @(posedge clk);
      tx_nak <= 1'b1;
      @(posedge clk);
      tx_nak <= 1'b0;
   endtask : nak
endmodule : ccm_host_model

// [dv/testbench.sv]
`timescale 1ns/1ps
module testbench
   import ccm_pkg::*;
;
   logic        clk, rst, avs_read, avs_write, wreq, irq, frame_tick;
   logic        tx_valid, tx_nak, rx_valid, cap_valid, opt_valid;
   logic [4:0]  cap_ch;
   logic [23:0] cap_data;
   ccm_opt_t    opt_slot;
   logic [5:0]  avs_address;
   logic [31:0] avs_writedata, avs_readdata;
   logic [7:0]  last_cnt;
   ccm_word_t   tx_word, rx_word;
   int          bad_count = 0;  // Mismatches seen
   int          n_compared = 0; // Comparisons made
   // Capture channels are filled once at start, each with its number
   ccm_mapper ccm_mapper_inst (.CORE_CLK(clk), .RST(rst),
      .AVS_ADDRESS(avs_address), .AVS_READ(avs_read),
      .AVS_WRITE(avs_write), .AVS_BYTEENABLE(4'hf),
      .AVS_WRITEDATA(avs_writedata), .AVS_READDATA(avs_readdata),
      .AVS_WAITREQUEST(wreq), .IRQ(irq), .CAP_VALID(cap_valid),
      .CAP_CH(cap_ch), .CAP_DATA(cap_data), .LINK_TX_VALID(tx_valid),
      .LINK_TX_WORD(tx_word), .LINK_TX_NAK(tx_nak),
      .LINK_RX_VALID(rx_valid), .LINK_RX_WORD(rx_word),
      .OPT_VALID(opt_valid), .OPT_SLOT(opt_slot), .SPDIF_STB(),
      .SPDIF_L(), .SPDIF_R(),
      .RATE_TICK(), .FRAME_TICK(frame_tick));
   ccm_host_model ccm_host_model_inst (.clk(clk), .rst(rst),
      .tx_valid(tx_valid), .tx_nak(tx_nak), .rx_valid(rx_valid),
      .rx_word(rx_word), .last_cnt(last_cnt));
   ////////////////////////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      n_compared++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic tally_and_finish();
      $display("compared %0d mismatches %0d", n_compared, bad_count);
      if (bad_count == 0 && n_compared > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask : tally_and_finish
   task automatic pause(input int n);
      repeat (n) @(posedge clk);
   endtask : pause
   // Held until waitrequest is seen low at an edge, then released
   task automatic bus(input logic wr, input logic [5:0] a,
                      input logic [31:0] v, output logic [31:0] d);
      avs_address   <= a;
      avs_writedata <= v;
      avs_write     <= wr;
      avs_read      <= !wr;
      @(posedge clk);
      while (wreq !== 1'b0) @(posedge clk);
      d = avs_readdata;
      avs_write <= 1'b0;
      avs_read  <= 1'b0;
      @(posedge clk);
   endtask : bus
   task automatic wait_frames(input int n);
      int k;
      k = 0;
      while (n > 0 && k < 9000) begin
         @(posedge clk);
         k++;
         if (frame_tick === 1'b1) n--;
      end
      check({31'h0, n == 0}, 32'h1);
   endtask : wait_frames
   task automatic t_regs();
      logic [31:0] d;
      bus(1'b0, REG_CTRL, 32'h0, d);
      check(d, 32'h0);
      bus(1'b0, REG_LATENCY, 32'h0, d);
      check(d, 32'h140);
      bus(1'b1, REG_BUFSZ, 32'h200, d);
      bus(1'b0, REG_LATENCY, 32'h0, d);
      check(d, 32'h240);
      bus(1'b0, 6'h3c, 32'h0, d);
      check(d, 32'h0);
   endtask : t_regs
   task automatic t_caps();
      logic [31:0] d;
      logic [4:0]  e;
      for (int r = 0; r < 3; r++) begin
         for (int c = 0; c < 4; c++) begin
            bus(1'b1, REG_CTRL, {26'h0, 2'b10, 2'(r), 2'(c)}, d);
            wait_frames(3);
            bus(1'b0, REG_ACTIVE, 32'h0, d);
            e = (c == 3) ? 5'h08 : (r == 2 || c == 2) ? 5'h0c :
                (c == 1 || r == 1) ? 5'h14 : 5'h1c;
            check({27'h0, d[4:0]}, {27'h0, e});
            check({31'h0, d[7]}, {31'h0, r == 1});
            check({24'h0, last_cnt}, {27'h0, e});
         end
      end
   endtask : t_caps
   task automatic t_optical();
      logic [31:0] d;
      int          k;
      bus(1'b1, REG_CTRL, 32'h24, d);
      wait_frames(2);
      k = 0;
      while (opt_valid !== 1'b1 && k < 2000) begin
         @(posedge clk);
         k++;
      end
      repeat (8) @(posedge clk);
      check({4'h0, opt_slot}, {4'h0, 1'b1, 3'h0, 24'h000004});
      @(posedge clk);
      check({3'h0, opt_valid, opt_slot}, {5'h01, 1'b1, 3'h1, 24'h4});
   endtask : t_optical
   task automatic t_errors();
      logic [31:0] p0, d;
      bus(1'b1, REG_MASK, 32'h7, d);
      ccm_host_model_inst.send(8'h10, 12, 1'b0);
      ccm_host_model_inst.send(8'h11, 12, 1'b0);
      pause(4);
      bus(1'b0, REG_POS, 32'h0, p0);
      ccm_host_model_inst.send(8'h14, 12, 1'b0);
      pause(4);
      bus(1'b0, REG_POS, 32'h0, d);
      check(d - p0, 32'h3);
      bus(1'b0, REG_STATUS, 32'h0, d);
      check(d, 32'h2);
      check({31'h0, irq}, 32'h1);
      bus(1'b1, REG_STATUS, 32'h2, d);
      check({31'h0, irq}, 32'h0);
      ccm_host_model_inst.send(8'h15, 12, 1'b1);
      pause(4);
      bus(1'b0, REG_STATUS, 32'h0, d);
      check(d, 32'h1);
      bus(1'b1, REG_STATUS, 32'h1, d);
      bus(1'b1, REG_MASK, 32'h0, d);
      ccm_host_model_inst.nak();
      pause(2);
      bus(1'b0, REG_STATUS, 32'h0, d);
      check(d, 32'h4);
      check({31'h0, irq}, 32'h0);
   endtask : t_errors
   ////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Known capture data keeps link words and parity defined
   initial begin
      cap_valid = 1'b0;
      for (int i = 0; i < 28; i++) begin
         @(posedge clk);
         cap_valid <= 1'b1;
         cap_ch    <= 5'(i);
         cap_data  <= 24'(i);
      end
      @(posedge clk);
      cap_valid <= 1'b0;
   end
   // Cuts a hang short well past the expected run length
   initial begin
      repeat (90000) @(posedge clk);
      bad_count++;
      tally_and_finish();
   end
   initial begin
      rst           = 1'b1;
      avs_address   = 6'h00;
      avs_read      = 1'b0;
      avs_write     = 1'b0;
      avs_writedata = 32'h0;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      t_regs();
      t_caps();
      t_optical();
      t_errors();
      tally_and_finish();
   end
endmodule : testbench
